// [design/terc_map.svh]
// Constants for the terminal enable and run control block
// Assumes inclusion by bare name from the top module and the bench
`ifndef TERC_MAP_SVH
`define TERC_MAP_SVH

// ****************************************
// Register offsets (byte addresses, low byte decoded)
// ****************************************
`define TERC_ADDR_W        8
`define TERC_CFG_OFFSET    8'h00
`define TERC_STAT_OFFSET   8'h04

// ****************************************
// Configuration register fields
// ****************************************
`define TERC_MON_EN_BIT    8
`define TERC_T2_EN_BIT     7
`define TERC_T1_EN_BIT     6
`define TERC_T2_START_BIT  5
`define TERC_T1_START_BIT  4
`define TERC_CFG_WMASK     32'h0000_01F0
`define TERC_CFG_RESET     32'h0000_0000

// ****************************************
// Status register fields
// ****************************************
`define TERC_ST_MON_ACT    0
`define TERC_ST_MON_DRAIN  1
`define TERC_ST_T1_RUN     2
`define TERC_ST_T2_RUN     3
`define TERC_ST_T1_ENA     4
`define TERC_ST_T2_ENA     5
`define TERC_ST_MON_ENA    6
`define TERC_ST_MON_PIN    8
`define TERC_ST_T1_PIN     9
`define TERC_ST_T2_PIN     10

// ****************************************
// Bus answer
// ****************************************
`define TERC_RDATA_RESET   32'h0000_0000

`endif

// [design/terc_pkg.sv]
// Types shared by the terminal enable and run control modules
// Assumes terc_map.svh is on the include path
package terc_pkg;
	// ****************************************
	// Monitor gate states
	// ****************************************
	typedef enum logic [2:0] {
		TERC_MON_IDLE  = 3'b001,
		TERC_MON_RUN   = 3'b010,
		TERC_MON_DRAIN = 3'b100
	} terc_mon_state_t;

	typedef logic [1:0] terc_term_vec_t;
endpackage

// [design/terc_mon_if.sv]
// Link between the control top and the monitor gate
// Assumes both ends run on hclk
`timescale 1ns/1ps
interface terc_mon_if;
	logic enable;
	logic msg_start;
	logic msg_busy;
	logic active;
	logic draining;

	modport ctl (
		output enable,
		output msg_start,
		output msg_busy,
		input  active,
		input  draining
	);

	modport gate (
		input  enable,
		input  msg_start,
		input  msg_busy,
		output active,
		output draining
	);
endinterface

// [design/terc_sync.sv]
// Two flip-flop synchroniser for a group of pin levels
// Assumes inputs are asynchronous levels; output is stable in hclk domain
`timescale 1ns/1ps
module terc_sync #(
	parameter int W = 3
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);
	logic [W-1:0] meta_q;
	logic [W-1:0] meta_d;
	logic [W-1:0] sync_q;
	logic [W-1:0] sync_d;

	always_comb begin
		meta_d = async_in;
		sync_d = meta_q;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end

	assign sync_out = sync_q;
endmodule // terc_sync

// [design/terc_mon_gate.sv]
// Monitor gate: starts and stops recording on message boundaries
// Assumes msg_start is a one-cycle pulse and msg_busy a level, both on hclk
`timescale 1ns/1ps
module terc_mon_gate
	import terc_pkg::*;
(
	input  wire logic clk,
	input  wire logic rst_n,
	terc_mon_if.gate  m
);
	terc_mon_state_t state_q;
	terc_mon_state_t state_d;
	logic            active_q;
	logic            active_d;
	logic            drain_q;
	logic            drain_d;

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		state_d = state_q;
		case (state_q)
			TERC_MON_IDLE: begin
				// Only a fresh qualifying message opens recording
				if (m.enable && m.msg_start) begin
					state_d = TERC_MON_RUN;
				end
			end
			TERC_MON_RUN: begin
				if (!m.enable) begin
					state_d = m.msg_busy ? TERC_MON_DRAIN : TERC_MON_IDLE;
				end
			end
			TERC_MON_DRAIN: begin
				if (!m.msg_busy) begin
					state_d = TERC_MON_IDLE;
				end
			end
			default: begin
				state_d = TERC_MON_IDLE;
			end
		endcase
		active_d = (state_d != TERC_MON_IDLE);
		drain_d  = (state_d == TERC_MON_DRAIN);
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q  <= TERC_MON_IDLE;
			active_q <= 1'b0;
			drain_q  <= 1'b0;
		end else begin
			state_q  <= state_d;
			active_q <= active_d;
			drain_q  <= drain_d;
		end
	end

	assign m.active   = active_q;
	assign m.draining = drain_q;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_mon_start_edge: assert property (
		$rose(active_q) |-> $past(m.enable) && $past(m.msg_start))
		else $error("Monitor started without a qualifying message start");
	a_mon_drain_hold: assert property (
		active_q && !m.enable && m.msg_busy |=> active_q)
		else $error("Monitor stopped inside a message");
	a_mon_drain_end: assert property (
		active_q && !m.enable && !m.msg_busy |=> !active_q)
		else $error("Monitor kept running after message ended while disabled");

	c_mon_start: cover property ($rose(active_q));
	c_mon_drain: cover property ($rose(drain_q) ##[1:20] !active_q);
endmodule // terc_mon_gate

// [design/terc_ctrl.sv]
// Terminal enable and run control with AHB-Lite register slave
// Assumes one AHB-Lite master; pins asynchronous; message events on hclk
`timescale 1ns/1ps
`include "terc_map.svh"
module terc_ctrl
	import terc_pkg::*;
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        monitor_run_pin,
	input  wire logic        terminal_one_enable_pin,
	input  wire logic        terminal_two_enable_pin,
	input  wire logic        msg_start_match,
	input  wire logic        msg_busy,
	output logic             monitor_active,
	output logic             monitor_enabled,
	output logic             terminal_one_enabled,
	output logic             terminal_two_enabled,
	output logic             terminal_one_running,
	output logic             terminal_two_running
);
	// ****************************************
	// Pin synchronisation
	// ****************************************
	logic [2:0]     pin_s;
	terc_term_vec_t term_pin;
	logic           mon_pin;

	terc_sync #(
		.W (3)
	) u_sync (
		.clk      (hclk),
		.rst_n    (hresetn),
		.async_in ({terminal_two_enable_pin, terminal_one_enable_pin, monitor_run_pin}),
		.sync_out (pin_s)
	);

	// Pins read low for two edges after reset
	assign mon_pin  = pin_s[0];
	assign term_pin = pin_s[2:1];

	// ****************************************
	// AHB-Lite slave
	// ****************************************
	logic                    wr_q;
	logic                    wr_d;
	logic [`TERC_ADDR_W-1:0] addr_q;
	logic [`TERC_ADDR_W-1:0] addr_d;
	logic [31:0]             rdata_q;
	logic [31:0]             rdata_d;
	logic                    accept;
	logic [31:0]             cfg_q;
	logic [31:0]             cfg_d;
	logic [31:0]             status;

	// Always zero wait state, so hready is this slave's own hreadyout
	assign accept = hsel && htrans[1] && hready;

	always_comb begin
		wr_d   = accept && hwrite;
		addr_d = accept ? haddr[`TERC_ADDR_W-1:0] : addr_q;
		cfg_d  = cfg_q;
		if (wr_q && (addr_q == `TERC_CFG_OFFSET)) begin
			cfg_d = hwdata & `TERC_CFG_WMASK;
			// A set is refused while the pin is low; a bit already set survives
			cfg_d[`TERC_T1_EN_BIT] = hwdata[`TERC_T1_EN_BIT]
				&& (term_pin[0] || cfg_q[`TERC_T1_EN_BIT]);
			cfg_d[`TERC_T2_EN_BIT] = hwdata[`TERC_T2_EN_BIT]
				&& (term_pin[1] || cfg_q[`TERC_T2_EN_BIT]);
		end
		// Read value taken from next config, so a read right after a write sees it
		rdata_d = rdata_q;
		if (accept && !hwrite) begin
			case (haddr[`TERC_ADDR_W-1:0])
				`TERC_CFG_OFFSET: begin
					rdata_d = cfg_d;
				end
				`TERC_STAT_OFFSET: begin
					rdata_d = status;
				end
				default: begin
					rdata_d = `TERC_RDATA_RESET;
				end
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_q    <= 1'b0;
			addr_q  <= '0;
			rdata_q <= `TERC_RDATA_RESET;
			cfg_q   <= `TERC_CFG_RESET;
		end else begin
			wr_q    <= wr_d;
			addr_q  <= addr_d;
			rdata_q <= rdata_d;
			cfg_q   <= cfg_d;
		end
	end

	// ****************************************
	// Terminal enable and run
	// ****************************************
	terc_term_vec_t term_en_q;
	terc_term_vec_t term_en_d;
	terc_term_vec_t term_run_q;
	terc_term_vec_t term_run_d;
	terc_term_vec_t term_en_bit;
	terc_term_vec_t term_start_bit;

	assign term_en_bit    = {cfg_q[`TERC_T2_EN_BIT], cfg_q[`TERC_T1_EN_BIT]};
	assign term_start_bit = {cfg_q[`TERC_T2_START_BIT], cfg_q[`TERC_T1_START_BIT]};

	// Registered outputs: a stop shows one edge after the drop
	for (genvar i = 0; i < 2; i++) begin : g_term
		always_comb begin
			term_en_d[i]  = term_en_bit[i] && term_pin[i];
			// Start bit, enable bit and pin together decide operation; any low input stops it next edge
			term_run_d[i] = term_en_d[i] && term_start_bit[i];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			term_en_q  <= '0;
			term_run_q <= '0;
		end else begin
			term_en_q  <= term_en_d;
			term_run_q <= term_run_d;
		end
	end

	// ****************************************
	// Monitor enable
	// ****************************************
	logic mon_en_q;
	logic mon_en_d;

	terc_mon_if mon_if ();

	// Registered so the gate sees one settled level per edge
	always_comb begin
		mon_en_d = cfg_q[`TERC_MON_EN_BIT] && mon_pin;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mon_en_q <= 1'b0;
		end else begin
			mon_en_q <= mon_en_d;
		end
	end

	assign mon_if.enable    = mon_en_q;
	assign mon_if.msg_start = msg_start_match;
	assign mon_if.msg_busy  = msg_busy;

	terc_mon_gate u_mon (
		.clk   (hclk),
		.rst_n (hresetn),
		.m     (mon_if.gate)
	);

	// ****************************************
	// Status and outputs
	// ****************************************
	always_comb begin
		// Read only: writes to status are dropped
		status                      = 32'h0000_0000;
		status[`TERC_ST_MON_ACT]    = mon_if.active;
		status[`TERC_ST_MON_DRAIN]  = mon_if.draining;
		status[`TERC_ST_T1_RUN]     = term_run_q[0];
		status[`TERC_ST_T2_RUN]     = term_run_q[1];
		status[`TERC_ST_T1_ENA]     = term_en_q[0];
		status[`TERC_ST_T2_ENA]     = term_en_q[1];
		status[`TERC_ST_MON_ENA]    = mon_en_q;
		status[`TERC_ST_MON_PIN]    = mon_pin;
		status[`TERC_ST_T1_PIN]     = term_pin[0];
		status[`TERC_ST_T2_PIN]     = term_pin[1];
	end

	// Fixed answers still come from flops to keep outputs glitch free
	logic hreadyout_q;
	logic hresp_q;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout_q <= 1'b1;
			hresp_q     <= 1'b0;
		end else begin
			hreadyout_q <= 1'b1;
			hresp_q     <= 1'b0;
		end
	end

	assign hrdata               = rdata_q;
	assign hreadyout            = hreadyout_q;
	assign hresp                = hresp_q;
	assign monitor_active       = mon_if.active;
	assign monitor_enabled      = mon_en_q;
	assign terminal_one_enabled = term_en_q[0];
	assign terminal_two_enabled = term_en_q[1];
	assign terminal_one_running = term_run_q[0];
	assign terminal_two_running = term_run_q[1];

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	a_mon_enable_and: assert property (
		##1 monitor_enabled == $past(cfg_q[`TERC_MON_EN_BIT] && mon_pin))
		else $error("Monitor enable is not bit AND pin");
	a_two_enable_and: assert property (
		##1 terminal_two_enabled == $past(cfg_q[`TERC_T2_EN_BIT] && term_pin[1]))
		else $error("Terminal two enable is not bit AND pin");
	a_one_enable_and: assert property (
		##1 terminal_one_enabled == $past(cfg_q[`TERC_T1_EN_BIT] && term_pin[0]))
		else $error("Terminal one enable is not bit AND pin");
	a_two_set_blocked: assert property (
		wr_q && addr_q == `TERC_CFG_OFFSET && !term_pin[1] && !cfg_q[`TERC_T2_EN_BIT]
		|=> !cfg_q[`TERC_T2_EN_BIT])
		else $error("Terminal two enable set while pin low");
	a_one_set_blocked: assert property (
		wr_q && addr_q == `TERC_CFG_OFFSET && !term_pin[0] && !cfg_q[`TERC_T1_EN_BIT]
		|=> !cfg_q[`TERC_T1_EN_BIT])
		else $error("Terminal one enable set while pin low");
	a_two_idle_nostart: assert property (
		!cfg_q[`TERC_T2_START_BIT] |=> !terminal_two_running)
		else $error("Terminal two runs without start bit");
	a_one_idle_nostart: assert property (
		!cfg_q[`TERC_T1_START_BIT] |=> !terminal_one_running)
		else $error("Terminal one runs without start bit");
	a_two_run_start: assert property (
		cfg_q[`TERC_T2_EN_BIT] && term_pin[1] && cfg_q[`TERC_T2_START_BIT] [*2]
		|=> terminal_two_running)
		else $error("Terminal two did not start");
	a_one_run_start: assert property (
		cfg_q[`TERC_T1_EN_BIT] && term_pin[0] && cfg_q[`TERC_T1_START_BIT] [*2]
		|=> terminal_one_running)
		else $error("Terminal one did not start");
	a_two_stop_now: assert property (
		terminal_two_running && !(term_pin[1] && cfg_q[`TERC_T2_EN_BIT]
		&& cfg_q[`TERC_T2_START_BIT]) |=> !terminal_two_running)
		else $error("Terminal two did not stop at once");
	a_one_stop_now: assert property (
		terminal_one_running && !(term_pin[0] && cfg_q[`TERC_T1_EN_BIT]
		&& cfg_q[`TERC_T1_START_BIT]) |=> !terminal_one_running)
		else $error("Terminal one did not stop at once");

	// Bus answer never waits and never errors
	a_bus_ready_okay: assert property (
		hreadyout && !hresp)
		else $error("Bus answer not ready or not OKAY");
	a_cfg_mask_zero: assert property (
		(cfg_q & ~`TERC_CFG_WMASK) == 32'h0000_0000)
		else $error("Unused configuration bit set");
	a_mon_bit_store: assert property (
		wr_q && addr_q == `TERC_CFG_OFFSET
		|=> cfg_q[`TERC_MON_EN_BIT] == $past(hwdata[`TERC_MON_EN_BIT]))
		else $error("Monitor enable bit not stored as written");
	a_mon_pin_off: assert property (
		!mon_pin |=> !monitor_enabled)
		else $error("Monitor enabled with pin low");
	a_two_pin_off: assert property (
		!term_pin[1] |=> !terminal_two_enabled && !terminal_two_running)
		else $error("Terminal two on with pin low");
	a_one_pin_off: assert property (
		!term_pin[0] |=> !terminal_one_enabled && !terminal_one_running)
		else $error("Terminal one on with pin low");
	a_mon_idle_off: assert property (
		!monitor_enabled && !monitor_active |=> !monitor_active)
		else $error("Monitor started while disabled");

	c_one_start: cover property ($rose(terminal_one_running));
	c_two_start: cover property ($rose(terminal_two_running));
	c_one_stop_pin: cover property (terminal_one_running ##1 !term_pin[0]);
endmodule // terc_ctrl

// [dv/terminal_enable_run_control_bench.sv]
// Self-checking bench for the terminal enable and run control block
// Assumes the design files are compiled first; bench acts as sole AHB-Lite master
`timescale 1ns/1ps
`include "terc_map.svh"
module terminal_enable_run_control_bench
	import terc_pkg::*;
;
	// ****************************************
	// Stimulus and wiring
	// ****************************************
	typedef struct {
		logic [2:0]  pins;
		logic [31:0] wd;
		logic [4:0]  outs;
		logic [31:0] cfg;
	} terc_row_t;

	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic        hsel = 1'b0;
	logic [31:0] haddr = 32'h0000_0000;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [2:0]  hsize = 3'h2;
	logic [31:0] hwdata = 32'h0000_0000;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic        monitor_run_pin = 1'b0;
	logic        terminal_one_enable_pin = 1'b0;
	logic        terminal_two_enable_pin = 1'b0;
	logic        msg_start_match = 1'b0;
	logic        msg_busy = 1'b0;
	logic        monitor_active;
	logic        monitor_enabled;
	logic        terminal_one_enabled;
	logic        terminal_two_enabled;
	logic        terminal_one_running;
	logic        terminal_two_running;
	logic [4:0]  outs;
	logic [31:0] rd;
	int          failures = 0;
	int          n_checks = 0;
	terc_row_t   rows [8];

	assign outs = {monitor_enabled, terminal_two_enabled, terminal_one_enabled,
		terminal_two_running, terminal_one_running};

	always #50 hclk = ~hclk;

	terc_ctrl u_dut (
		.hclk                    (hclk),
		.hresetn                 (hresetn),
		.hsel                    (hsel),
		.haddr                   (haddr),
		.htrans                  (htrans),
		.hwrite                  (hwrite),
		.hsize                   (hsize),
		.hwdata                  (hwdata),
		.hready                  (hreadyout),
		.hrdata                  (hrdata),
		.hreadyout               (hreadyout),
		.hresp                   (hresp),
		.monitor_run_pin         (monitor_run_pin),
		.terminal_one_enable_pin (terminal_one_enable_pin),
		.terminal_two_enable_pin (terminal_two_enable_pin),
		.msg_start_match         (msg_start_match),
		.msg_busy                (msg_busy),
		.monitor_active          (monitor_active),
		.monitor_enabled         (monitor_enabled),
		.terminal_one_enabled    (terminal_one_enabled),
		.terminal_two_enabled    (terminal_two_enabled),
		.terminal_one_running    (terminal_one_running),
		.terminal_two_running    (terminal_two_running)
	);

	// ****************************************
	// Tasks
	// ****************************************
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: %s got %h exp %h", $time, msg, got, exp);
		end
	endtask

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge hclk);
		#1;
	endtask

	// Single AHB-Lite transfer; waits on hready, no fixed latency assumed
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d,
		output logic [31:0] r);
		@(posedge hclk);
		hsel   <= 1'b1;
		haddr  <= a;
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		r = hrdata;
		check({31'h0, hresp}, 32'h0, "response");
	endtask

	task automatic set_pins(input logic [2:0] p);
		@(posedge hclk);
		{monitor_run_pin, terminal_two_enable_pin, terminal_one_enable_pin} <= p;
		wait_cyc(4);
	endtask

	task automatic busy(input logic b, input logic s);
		@(posedge hclk);
		msg_busy        <= b;
		msg_start_match <= s;
		@(posedge hclk);
		msg_start_match <= 1'b0;
		#1;
	endtask

	// ****************************************
	// Watchdog
	// ****************************************
	initial begin
		repeat (20000) @(posedge hclk);
		failures++;
		end_of_test();
	end

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		// pins {mon, two, one}, write data, outputs {men, t2e, t1e, t2r, t1r}, cfg read
		rows[0] = '{3'h7, 32'h0000_01F0, 5'h1F, 32'h0000_01F0};
		rows[1] = '{3'h7, 32'h0000_00C0, 5'h0C, 32'h0000_00C0};
		rows[2] = '{3'h7, 32'h0000_0030, 5'h00, 32'h0000_0030};
		rows[3] = '{3'h0, 32'h0000_01F0, 5'h00, 32'h0000_0130};
		rows[4] = '{3'h4, 32'h0000_01F0, 5'h10, 32'h0000_0130};
		rows[5] = '{3'h2, 32'h0000_01F0, 5'h0A, 32'h0000_01B0};
		rows[6] = '{3'h1, 32'h0000_01F0, 5'h05, 32'h0000_0170};
		rows[7] = '{3'h7, 32'hFFFF_FE0F, 5'h00, 32'h0000_0000};
		wait_cyc(1);
		check({27'h0, outs}, 32'h0, "outputs in reset");
		check({30'h0, hreadyout, hresp}, 32'h2, "bus idle in reset");
		@(posedge hclk);
		hresetn <= 1'b1;
		bus(1'b0, 32'h0000_0000, 32'h0, rd);
		check(rd, `TERC_CFG_RESET, "cfg reset value");
		check({27'h0, outs}, 32'h0, "outputs after reset");
		$display("test reset done");

		foreach (rows[i]) begin
			set_pins(rows[i].pins);
			bus(1'b1, 32'h0000_0000, 32'h0, rd);
			bus(1'b1, 32'h0000_0000, rows[i].wd, rd);
			wait_cyc(3);
			check({27'h0, outs}, {27'h0, rows[i].outs}, "gated outputs");
			bus(1'b0, 32'h0000_0000, 32'h0, rd);
			check(rd, rows[i].cfg, "cfg readback");
		end
		$display("test table done");

		// Unmapped place and read-only status
		bus(1'b1, 32'h0000_0008, 32'hFFFF_FFFF, rd);
		bus(1'b0, 32'h0000_0008, 32'h0, rd);
		check(rd, 32'h0, "unmapped read");
		bus(1'b1, 32'h0000_0004, 32'hFFFF_FFFF, rd);
		bus(1'b0, 32'h0000_0000, 32'h0, rd);
		check(rd, 32'h0, "status write leaks");
		$display("test unmapped done");

		// Each cause of a stop, the start bit taking one edge
		bus(1'b1, 32'h0000_0000, 32'h0000_00F0, rd);
		wait_cyc(2);
		check({27'h0, outs}, 32'h0F, "both running");
		bus(1'b0, 32'h0000_0004, 32'h0, rd);
		check(rd, 32'h0000_073C, "status both running");
		set_pins(3'h5);
		check({27'h0, outs}, 32'h05, "two pin drop");
		bus(1'b0, 32'h0000_0000, 32'h0, rd);
		check(rd, 32'h0000_00F0, "set bit kept on pin drop");
		set_pins(3'h6);
		check({27'h0, outs}, 32'h0A, "one pin drop");
		set_pins(3'h7);
		bus(1'b1, 32'h0000_0000, 32'h0000_00E0, rd);
		wait_cyc(1);
		check({27'h0, outs}, 32'h0E, "one start cleared");
		bus(1'b1, 32'h0000_0000, 32'h0000_0060, rd);
		wait_cyc(1);
		check({27'h0, outs}, 32'h04, "two enable cleared");
		$display("test stop done");

		// Monitor joins and leaves only at message boundaries
		bus(1'b1, 32'h0000_0000, 32'h0000_0100, rd);
		wait_cyc(3);
		busy(1'b1, 1'b0);
		wait_cyc(3);
		check({31'h0, monitor_active}, 32'h0, "picked up mid message");
		busy(1'b0, 1'b0);
		busy(1'b1, 1'b1);
		wait_cyc(1);
		check({31'h0, monitor_active}, 32'h1, "start on match");
		bus(1'b1, 32'h0000_0000, 32'h0, rd);
		wait_cyc(4);
		check({31'h0, monitor_active}, 32'h1, "message cut short");
		bus(1'b0, 32'h0000_0004, 32'h0, rd);
		check(rd, 32'h0000_0703, "status draining");
		busy(1'b0, 1'b0);
		wait_cyc(1);
		check({31'h0, monitor_active}, 32'h0, "stop after message");
		bus(1'b1, 32'h0000_0000, 32'h0000_0100, rd);
		wait_cyc(3);
		busy(1'b0, 1'b1);
		wait_cyc(1);
		check({31'h0, monitor_active}, 32'h1, "restart on match");
		set_pins(3'h3);
		check({31'h0, monitor_active}, 32'h0, "pin drop between messages");
		$display("test monitor done");

		// Second reset clears the stored bits
		set_pins(3'h7);
		bus(1'b1, 32'h0000_0000, 32'h0000_01F0, rd);
		@(posedge hclk);
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		bus(1'b0, 32'h0000_0000, 32'h0, rd);
		check(rd, 32'h0, "cfg after second reset");
		check({27'h0, outs}, 32'h0, "outputs after second reset");
		$display("test second reset done");
		end_of_test();
	end
endmodule // terminal_enable_run_control_bench
